// ==== clock_output_enable_gating_tb.sv ====
// Self-checking bench for the enable gating block
`timescale 1ns/1ps
`default_nettype none
module clock_output_enable_gating_tb;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  wire [5:0] oe_pin_i;
  wire prog_mode_i, reg_wr_i;
  wire [7:0] reg_addr_i, reg_wdata_i, ctrl_byte1_o, ctrl_byte2_o;
  wire wr_done_o, wr_reject_o, clocks_stable_o;
  wire [5:0] buffered_clock_out_o, out_running_o;
  int n_mismatch = 0;
  int n_compared = 0;
  int e1 = 8'h15;
  int e2 = 8'hE0;
  always #4 mclk_i = ~mclk_i;
  coeg_top #(.SETTLE_CYCLES(20'h00010)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .oe_pin_i(oe_pin_i),
    .prog_mode_i(prog_mode_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .ctrl_byte1_o(ctrl_byte1_o), .ctrl_byte2_o(ctrl_byte2_o), .wr_done_o(wr_done_o), .wr_reject_o(wr_reject_o),
    .clocks_stable_o(clocks_stable_o), .buffered_clock_out_o(buffered_clock_out_o), .out_running_o(out_running_o));
  coeg_ctl u_ctl (.mclk_i(mclk_i), .oe_pin_o(oe_pin_i), .prog_o(prog_mode_i), .wr_o(reg_wr_i),
    .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  function automatic logic [5:0] mask();
    return {e2[5], e2[6], e2[7], e1[0], e1[2], e1[4]} & oe_pin_i;
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrc(input logic [7:0] a, d, input logic p);
    logic ok;
    ok = p && (a == 8'h01 || a == 8'h02);
    u_ctl.wr(a, d, p);
    if (ok && a == 8'h01) e1 = d;
    if (ok && a == 8'h02) e2 = d;
    #1;
    chk("done", {7'h00, ok}, {7'h00, wr_done_o});
    chk("reject", {7'h00, !ok}, {7'h00, wr_reject_o});
    chk("byte1", e1[7:0], ctrl_byte1_o);
    chk("byte2", e2[7:0], ctrl_byte2_o);
  endtask
  task automatic clk_chk();
    logic [5:0] a;
    @(posedge mclk_i);
    #1 a = buffered_clock_out_o;
    chk("running", {2'h0, mask()}, {2'h0, out_running_o});
    @(posedge mclk_i);
    #1;
    chk("phase", {2'h0, mask()}, {2'h0, a | buffered_clock_out_o});
    chk("overlap", 8'h00, {2'h0, a & buffered_clock_out_o});
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge mclk_i);
    n_mismatch++;
    test_done();
  end
  initial begin
    void'($urandom(32'h3839));
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("byte1", 8'h15, ctrl_byte1_o);
    chk("byte2", 8'hE0, ctrl_byte2_o);
    chk("idle", 8'h00, {buffered_clock_out_o, 1'b0, clocks_stable_o});
    chk("idle_run", 8'h00, {2'h0, out_running_o});
    // Settle length 16: still low after 15 edges out of reset, high after 16
    repeat (15) @(posedge mclk_i);
    #1;
    chk("early", 8'h00, {buffered_clock_out_o, 1'b0, clocks_stable_o});
    @(posedge mclk_i);
    #1;
    chk("settled", 8'h01, {7'h00, clocks_stable_o});
    repeat (4) @(posedge mclk_i);
    clk_chk();
    wrc(8'h01, 8'h00, 1'b0);
    wrc(8'h03, 8'hFF, 1'b1);
    for (int i = 0; i < 12; i++) begin
      wrc(8'h01, 8'($urandom), 1'b1);
      wrc(8'h02, 8'($urandom), 1'b1);
      u_ctl.pins(6'($urandom));
      repeat (20) @(posedge mclk_i);
      clk_chk();
    end
    test_done();
  end
endmodule
`default_nettype wire

// ==== coeg_consts.vh ====
// Constants for the clock output enable gating block
`ifndef COEG_CONSTS_VH
`define COEG_CONSTS_VH

`define COEG_NUM_OUT 6
`define COEG_BYTE_W 8
`define COEG_ADDR_W 8

// Byte indices of the enable registers
`define COEG_ADDR_BYTE1 8'h01
`define COEG_ADDR_BYTE2 8'h02

// Power-up values of the enable registers
`define COEG_BYTE1_RST 8'h15
`define COEG_BYTE2_RST 8'hE0

// Enable bit positions
`define COEG_OUT0_BIT 4
`define COEG_OUT1_BIT 2
`define COEG_OUT2_BIT 0
`define COEG_OUT3_BIT 7
`define COEG_OUT4_BIT 6
`define COEG_OUT5_BIT 5

// Settle time after power-up: 5 ms of the 125 MHz reference, in clock cycles
`define COEG_SETTLE_CYC 20'h98968
`define COEG_SETTLE_W 20
`define COEG_CNT_ONE 20'h00001
`define COEG_CNT_ZERO 20'h00000

`endif

// ==== coeg_ctl.sv ====
// System controller model: enable pins and register writes
`timescale 1ns/1ps
`default_nettype none
module coeg_ctl (
  input wire logic mclk_i,
  output logic [5:0] oe_pin_o,
  output logic prog_o,
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // Pins always driven, never left to the pull resistor
  initial begin
    oe_pin_o = 6'h3F;
    prog_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [7:0] a, d, input logic p);
    @(posedge mclk_i);
    prog_o <= p;
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    prog_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic pins(input logic [5:0] v);
    @(posedge mclk_i);
    oe_pin_o <= v;
  endtask
endmodule
`default_nettype wire

// ==== coeg_gate.v ====
// One gated clock output, switched only at a low phase boundary
`timescale 1ns/1ps
`default_nettype none

module coeg_gate (
  input wire mclk_i,
  input wire rst_n_i,
  input wire phase_next_i,
  input wire enable_i,
  output reg clk_out_o,
  output reg running_o
);

  reg run_q;
  reg run_d;

  always @* begin
    run_d = run_q;
    // Only change state when the coming output level is low
    if (!phase_next_i) begin
      run_d = enable_i;
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      run_q <= 1'b0;
      clk_out_o <= 1'b0;
      running_o <= 1'b0;
    end else begin
      run_q <= run_d;
      // High phase only follows a full low phase, so no runt pulse
      clk_out_o <= phase_next_i & run_d;
      running_o <= run_d;
    end
  end

endmodule

`default_nettype wire

// ==== coeg_props.sv ====
// Port checker for the enable gating block
`timescale 1ns/1ps
`default_nettype none
module coeg_props (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] oe_pin_i,
  input wire logic prog_mode_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] ctrl_byte1_o,
  input wire logic [7:0] ctrl_byte2_o,
  input wire logic wr_done_o,
  input wire logic wr_reject_o,
  input wire logic clocks_stable_o,
  input wire logic [5:0] buffered_clock_out_o,
  input wire logic [5:0] out_running_o
);
  wire [5:0] ck = buffered_clock_out_o;
  wire [5:0] rn = out_running_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_pulse; ck != 6'h00 |=> ck == 6'h00; endproperty
  a_pulse: assert property (p_pulse) else $error("long high");
  property p_low; (ck & ~rn) == 6'h00; endproperty
  a_low: assert property (p_low) else $error("stopped clock high");
  property p_off; !clocks_stable_o |-> ck == 6'h00 && rn == 6'h00; endproperty
  a_off: assert property (p_off) else $error("clock before settle");
  property p_start; $rose(oe_pin_i[0]) && ctrl_byte1_o[4] && clocks_stable_o |-> ##[4:12] ck[0]; endproperty
  a_start: assert property (p_start) else $error("late start");
  property p_stop; $fell(oe_pin_i[3]) |-> ##7 (ck[3] == 1'b0) [*4]; endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_bit; $fell(ctrl_byte2_o[5]) |-> ##4 !rn[5]; endproperty
  a_bit: assert property (p_bit) else $error("bit stop");
  property p_wr; reg_wr_i && prog_mode_i && reg_addr_i == 8'h01 |=> wr_done_o && ctrl_byte1_o == $past(reg_wdata_i); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_rej; reg_wr_i && !prog_mode_i |=> wr_reject_o && $stable(ctrl_byte1_o) && $stable(ctrl_byte2_o); endproperty
  a_rej: assert property (p_rej) else $error("write taken");
  property p_rst; $rose(rst_n_i) |-> ctrl_byte1_o == 8'h15 && ctrl_byte2_o == 8'hE0; endproperty
  a_rst: assert property (p_rst) else $error("reset bytes");
  c_start: cover property ($rose(ck[0]));
  c_rej: cover property (wr_reject_o);
  c_stop: cover property ($fell(rn[3]));
endmodule
bind coeg_top coeg_props u_props (.*);
`default_nettype wire

// ==== coeg_top.v ====
// Output enable gating for six buffered clock outputs
// Function
// - An output runs only when its pin enable and its enable bit are high.
// - Either a low pin or a cleared enable bit alone stops the output.
// - Each output stops and starts alone; the other outputs keep running.
// - Resuming output gives only full-width pulses, never short or stretched.
// - Output becomes active two to six output cycles after its pin rises.
// - A disabled output is held statically low.
// - Stable outputs are delivered no later than 5 ms after clock is valid; here the first high comes three to four edges after 5 ms.
// - Enable registers take their defaults at power-up; writes are optional.
// - Register changes are accepted only in program mode.
// - Outputs zero, one, two enables sit at byte one bits 4, 2, 0.
// - Outputs three, four, five enables sit at byte two bits 7, 6, 5.
`timescale 1ns/1ps
`default_nettype none
`include "coeg_consts.vh"

module coeg_top #(
  parameter [`COEG_SETTLE_W-1:0] SETTLE_CYCLES = `COEG_SETTLE_CYC
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [`COEG_NUM_OUT-1:0] oe_pin_i,
  input wire prog_mode_i,
  input wire reg_wr_i,
  input wire [`COEG_ADDR_W-1:0] reg_addr_i,
  input wire [`COEG_BYTE_W-1:0] reg_wdata_i,
  output reg [`COEG_BYTE_W-1:0] ctrl_byte1_o,
  output reg [`COEG_BYTE_W-1:0] ctrl_byte2_o,
  output reg wr_done_o,
  output reg wr_reject_o,
  output reg clocks_stable_o,
  output wire [`COEG_NUM_OUT-1:0] buffered_clock_out_o,
  output wire [`COEG_NUM_OUT-1:0] out_running_o
);

  // Pin synchroniser; first stage read only by the second
  reg [`COEG_NUM_OUT-1:0] oe_meta_q;
  reg [`COEG_NUM_OUT-1:0] oe_sync_q;

  // Enable registers
  reg [`COEG_BYTE_W-1:0] byte1_q;
  reg [`COEG_BYTE_W-1:0] byte1_d;
  reg [`COEG_BYTE_W-1:0] byte2_q;
  reg [`COEG_BYTE_W-1:0] byte2_d;
  reg wr_done_d;
  reg wr_reject_d;

  // Settle counter and reference phase
  reg [`COEG_SETTLE_W-1:0] settle_cnt_q;
  reg [`COEG_SETTLE_W-1:0] settle_cnt_d;
  reg stable_q;
  reg stable_d;
  reg phase_q;
  wire phase_d;

  // Combined enables
  wire [`COEG_NUM_OUT-1:0] bit_en;
  reg [`COEG_NUM_OUT-1:0] comb_en_q;
  wire [`COEG_NUM_OUT-1:0] comb_en_d;

  // the pins are assumed driven; the synchroniser only removes metastability
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      oe_meta_q <= {`COEG_NUM_OUT{1'b0}};
      oe_sync_q <= {`COEG_NUM_OUT{1'b0}};
    end else begin
      oe_meta_q <= oe_pin_i;
      oe_sync_q <= oe_meta_q;
    end
  end

  // Register writes, gated by program mode
  always @* begin
    byte1_d = byte1_q;
    byte2_d = byte2_q;
    wr_done_d = 1'b0;
    wr_reject_d = 1'b0;
    if (reg_wr_i) begin
      if (!prog_mode_i) begin
        // Writes outside program mode are dropped and flagged
        wr_reject_d = 1'b1;
      end else if (reg_addr_i == `COEG_ADDR_BYTE1) begin
        byte1_d = reg_wdata_i;
        wr_done_d = 1'b1;
      end else if (reg_addr_i == `COEG_ADDR_BYTE2) begin
        byte2_d = reg_wdata_i;
        wr_done_d = 1'b1;
      end else begin
        // Other bytes belong to functions outside this block
        wr_reject_d = 1'b1;
      end
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      byte1_q <= `COEG_BYTE1_RST;
      byte2_q <= `COEG_BYTE2_RST;
    end else begin
      byte1_q <= byte1_d;
      byte2_q <= byte2_d;
    end
  end

  // Write answer pulses; each stands one cycle
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wr_done_o <= 1'b0;
      wr_reject_o <= 1'b0;
    end else begin
      wr_done_o <= wr_done_d;
      wr_reject_o <= wr_reject_d;
    end
  end

  // Readback mirrors the stored bytes, reserved bits included
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl_byte1_o <= `COEG_BYTE1_RST;
      ctrl_byte2_o <= `COEG_BYTE2_RST;
    end else begin
      ctrl_byte1_o <= byte1_d;
      ctrl_byte2_o <= byte2_d;
    end
  end

  // Byte one carries outputs zero to two
  assign bit_en[0] = byte1_q[`COEG_OUT0_BIT];
  assign bit_en[1] = byte1_q[`COEG_OUT1_BIT];
  assign bit_en[2] = byte1_q[`COEG_OUT2_BIT];
  // Byte two carries outputs three to five
  assign bit_en[3] = byte2_q[`COEG_OUT3_BIT];
  assign bit_en[4] = byte2_q[`COEG_OUT4_BIT];
  assign bit_en[5] = byte2_q[`COEG_OUT5_BIT];

  // Pin and bit must both be high; either low stops the output
  assign comb_en_d = oe_sync_q & bit_en & {`COEG_NUM_OUT{stable_q}};

  // Settle sequencer: outputs are held low until the reference has run long enough.
  // Counting the full time puts the first output high three to four edges past the 5 ms bound.
  localparam SETTLE_COUNT = 1'b0;
  localparam SETTLE_DONE = 1'b1;
  localparam [`COEG_SETTLE_W-1:0] SETTLE_LAST = SETTLE_CYCLES - `COEG_CNT_ONE;

  always @* begin
    settle_cnt_d = settle_cnt_q;
    stable_d = stable_q;
    case (stable_q)
      SETTLE_COUNT: begin
        if (settle_cnt_q >= SETTLE_LAST) begin
          stable_d = SETTLE_DONE;
        end else begin
          settle_cnt_d = settle_cnt_q + `COEG_CNT_ONE;
        end
      end
      SETTLE_DONE: begin
        // Stays open until the next reset
        stable_d = SETTLE_DONE;
      end
      default: begin
        stable_d = SETTLE_COUNT;
      end
    endcase
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      settle_cnt_q <= `COEG_CNT_ZERO;
      stable_q <= SETTLE_COUNT;
      clocks_stable_o <= 1'b0;
    end else begin
      settle_cnt_q <= settle_cnt_d;
      stable_q <= stable_d;
      clocks_stable_o <= stable_d;
    end
  end

  // Start path: two sync flops, this flop, then the gate waits for a low phase.
  // A pin that rises shows its first high five to six edges later, well inside
  // two to six output cycles; a written bit acts two to three edges after its write.
  // The extra flop costs one edge but keeps the gates free of decode glitches.
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      comb_en_q <= {`COEG_NUM_OUT{1'b0}};
    end else begin
      comb_en_q <= comb_en_d;
    end
  end

  // Free-running reference phase; outputs run at half the clock rate.
  // This phase never stops, so the other outputs are unaffected by any gate.
  assign phase_d = ~phase_q;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
    end
  end

  // One independent gate per output
  genvar gi;
  generate
    for (gi = 0; gi < `COEG_NUM_OUT; gi = gi + 1) begin : g_out
      coeg_gate u_gate (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .phase_next_i(phase_d),
        .enable_i(comb_en_q[gi]),
        .clk_out_o(buffered_clock_out_o[gi]),
        .running_o(out_running_o[gi])
      );
    end
  endgenerate

endmodule

`default_nettype wire
